//--- core/tcc_timer.sv
// Purpose: capture, clock select, force and 16-bit access of timer
// Assumes: pins synchronous to clock; one access per cycle
// Notes: waveform pwm output shaping and compare b are elsewhere
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module tcc_timer (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // register port
    input wire tcc_pkg::tcc_bus_t bus,
    output logic [7:0] rdata,
    // external pins
    input wire tcc_pkg::tcc_pins_t pins,
    // interrupt handshake
    input wire logic capture_vector_taken,
    output logic capture_irq,
    // waveform outputs
    output logic wave_out_a,
    output logic wave_out_b
);
    import tcc_pkg::*;

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [7:0] temp_q;
    logic [15:0] cnt_q;
    logic [15:0] cap_q;
    logic [15:0] cmpa_q;
    logic flag_q;
    logic [1:0] ien_q;
    logic [PRE_W-1:0] pre_q;
    logic ext_prev_q;
    logic [FILT_SAMPLES-1:0] samp_q;
    logic filt_q;
    logic lvl_prev_q;
    logic blk_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic wa_q;
    logic wb_q;

    // ------------------------------------------------
    // address decode
    // ------------------------------------------------
    wire wr = bus.wr;
    wire rd = bus.rd;
    wire [7:0] a = bus.addr;
    wire [7:0] wd = bus.wdata;
    wire hit_a = a == OFS_CTRL_A;
    wire hit_b = a == OFS_CTRL_B;
    wire hit_c = a == OFS_CTRL_C;
    wire hit_cnt_l = a == OFS_CNT;
    wire hit_cnt_h = a == OFS_CNT + OFS_HIGH;
    wire hit_cap_l = a == OFS_CAP;
    wire hit_cap_h = a == OFS_CAP + OFS_HIGH;
    wire hit_cmp_l = a == OFS_CMPA;
    wire hit_cmp_h = a == OFS_CMPA + OFS_HIGH;
    wire hit_st = a == OFS_STAT;
    wire hit_ien = a == OFS_IEN;
    wire any_hi = hit_cnt_h | hit_cap_h | hit_cmp_h;

    // ------------------------------------------------
    // mode decode
    // ------------------------------------------------
    wire [3:0] wave_mode_field = {ctrl_b_q[B_WM3], ctrl_b_q[B_WM2],
                                  ctrl_a_q[1:0]};
    wire [2:0] count_clock_select = ctrl_b_q[2:0];
    wire capture_noise_filter_en = ctrl_b_q[B_NOISE];
    wire capture_edge_select = ctrl_b_q[B_EDGE];
    wire [1:0] act_a = ctrl_a_q[B_ACT_A +: 2];
    wire [1:0] act_b = ctrl_a_q[B_ACT_B +: 2];
    wire cap_top = wave_mode_field == 4'h8
                 | wave_mode_field == 4'ha
                 | wave_mode_field == 4'hc
                 | wave_mode_field == 4'he;
    wire cmp_top = wave_mode_field == 4'h4
                 | wave_mode_field == 4'h9
                 | wave_mode_field == 4'hb
                 | wave_mode_field == 4'hf;
    wire non_pwm = wave_mode_field == 4'h0
                 | wave_mode_field == 4'h4
                 | wave_mode_field == 4'hc;
    wire [15:0] top_val = cap_top ? cap_q
                        : cmp_top ? cmpa_q
                        : MAX_WORD;

    // ------------------------------------------------
    // clock source
    // ------------------------------------------------
    // one shared divider; taps fire once per period
    wire tap8 = &pre_q[2:0];
    wire tap64 = &pre_q[5:0];
    wire tap256 = &pre_q[7:0];
    wire tap1024 = &pre_q[9:0];
    wire ext_now = pins.ext_count_clock_pin;
    wire ext_fall = ext_prev_q & ~ext_now;
    wire ext_rise = ~ext_prev_q & ext_now;
    logic tick;
    always_comb begin
        unique case (count_clock_select)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = tap8;
            CS_DIV64: tick = tap64;
            CS_DIV256: tick = tap256;
            CS_DIV1024: tick = tap1024;
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
        endcase
    end

    // ------------------------------------------------
    // capture input path
    // ------------------------------------------------
    // source mux sits ahead of the filter so both share it
    wire cap_src = ien_q[B_CAP_SRC] ? pins.comparator_out
                                    : pins.capture_pin;
    wire samp_same = &samp_q | ~|samp_q;
    wire lvl = capture_noise_filter_en ? filt_q : samp_q[0];
    wire edge_hit = capture_edge_select ? (lvl & ~lvl_prev_q)
                                        : (~lvl & lvl_prev_q);
    wire cap_evt = edge_hit & ~cap_top;

    // ------------------------------------------------
    // counter and compare
    // ------------------------------------------------
    wire cnt_wr = wr & hit_cnt_l;
    wire at_top = cnt_q == top_val;
    wire [15:0] cnt_inc = at_top ? RST_WORD : cnt_q + 16'h0001;
    wire match_a = tick & ~blk_q & cnt_q == cmpa_q;
    wire top_flag = tick & at_top & cap_top;
    wire force_ok = wr & hit_c & non_pwm;
    wire force_a = force_ok & wd[B_FORCE_A];
    wire force_b = force_ok & wd[B_FORCE_B];

    function automatic logic apply(input logic cur,
                                   input logic [1:0] act);
        logic r;
        r = cur;
        unique case (act)
            ACT_TOGGLE: r = ~cur;
            ACT_CLEAR: r = 1'b0;
            ACT_SET: r = 1'b1;
            default: r = cur;
        endcase
        return r;
    endfunction

    // pwm output shaping lives in the waveform unit
    wire wa_next = (force_a | (match_a & non_pwm))
                 ? apply(wa_q, act_a) : wa_q;
    wire wb_next = force_b ? apply(wb_q, act_b) : wb_q;

    // ------------------------------------------------
    // read mux
    // ------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = RST_BYTE;
        if (hit_a)
            rd_mux = ctrl_a_q;
        if (hit_b)
            rd_mux = ctrl_b_q;
        if (hit_cnt_l)
            rd_mux = cnt_q[7:0];
        if (hit_cap_l)
            rd_mux = cap_q[7:0];
        if (hit_cmp_l)
            rd_mux = cmpa_q[7:0];
        if (any_hi)
            rd_mux = temp_q;
        if (hit_st)
            rd_mux = {7'h00, flag_q};
        if (hit_ien)
            rd_mux = {6'h00, ien_q};
    end // hit_c falls through to zero

    // ------------------------------------------------
    // sequential
    // ------------------------------------------------
    wire flag_set = cap_evt | top_flag;
    wire flag_clr = capture_vector_taken
                  | (wr & hit_st & wd[B_FLAG]);

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_a_q <= RST_BYTE;
            ctrl_b_q <= RST_BYTE;
            ien_q <= 2'h0;
        end else begin
            if (wr & hit_a)
                ctrl_a_q <= wd;
            if (wr & hit_b)
                ctrl_b_q <= wd & CTRL_B_MASK;
            if (wr & hit_ien)
                ien_q <= wd[1:0];
        end
    end

    // temp byte shared by every 16-bit pair
    always_ff @(posedge clock) begin
        if (srst)
            temp_q <= RST_BYTE;
        else if (wr & any_hi)
            temp_q <= wd;
        else if (rd & hit_cnt_l)
            temp_q <= cnt_q[15:8];
        else if (rd & hit_cap_l)
            temp_q <= cap_q[15:8];
        else if (rd & hit_cmp_l)
            temp_q <= cmpa_q[15:8];
    end

    // a software write wins over a same-cycle count
    always_ff @(posedge clock) begin
        if (srst)
            cnt_q <= RST_WORD;
        else if (cnt_wr)
            cnt_q <= {temp_q, wd};
        else if (tick)
            cnt_q <= cnt_inc;
    end

    always_ff @(posedge clock) begin
        if (srst)
            blk_q <= 1'b0;
        else if (cnt_wr)
            blk_q <= 1'b1;
        else if (tick)
            blk_q <= 1'b0;
    end

    always_ff @(posedge clock) begin
        if (srst)
            cap_q <= RST_WORD;
        else if (cap_evt)
            cap_q <= cnt_q;
        else if (wr & hit_cap_l)
            cap_q <= {temp_q, wd};
    end

    always_ff @(posedge clock) begin
        if (srst)
            cmpa_q <= RST_WORD;
        else if (wr & hit_cmp_l)
            cmpa_q <= {temp_q, wd};
    end

    // set beats a same-cycle clear so no event is lost
    always_ff @(posedge clock) begin
        if (srst)
            flag_q <= 1'b0;
        else
            flag_q <= flag_set | (flag_q & ~flag_clr);
    end

    always_ff @(posedge clock) begin
        if (srst)
            pre_q <= '0;
        else
            pre_q <= pre_q + PRE_W'(1);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ext_prev_q <= 1'b0;
            samp_q <= '0;
            filt_q <= 1'b0;
            lvl_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_now;
            samp_q <= {samp_q[FILT_SAMPLES-2:0], cap_src};
            if (samp_same)
                filt_q <= samp_q[FILT_SAMPLES-1];
            lvl_prev_q <= lvl;
        end
    end

    // ------------------------------------------------
    // outputs
    // ------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= RST_BYTE;
            irq_q <= 1'b0;
            wa_q <= 1'b0;
            wb_q <= 1'b0;
        end else begin
            rdata_q <= rd ? rd_mux : RST_BYTE;
            irq_q <= flag_q & ien_q[B_CAP_IEN] & ~flag_clr;
            wa_q <= wa_next;
            wb_q <= wb_next;
        end
    end

    assign rdata = rdata_q;
    assign capture_irq = irq_q;
    assign wave_out_a = wa_q;
    assign wave_out_b = wb_q;

endmodule

//--- pkg/tcc_pkg.sv
// Purpose: constants and types of the 16-bit timer control slice
// Assumes: byte-wide register port, one 100 MHz clock
// Notes: offsets are byte addresses on the register port
//
// Summary of operation
// - filter output changes after four equal samples
// - filtered capture lags unfiltered by four cycles
// - edge select: zero falling, one rising
// - capture copies counter into capture register
// - capture sets flag; irq only when enabled
// - capture off when capture register is top
// - clock select 0 stop,1,8,64,256,1024 divide
// - select 6 falling, 7 rising external clock
// - force strobes act only in non-pwm modes
// - force applies compare action to its output
// - force sets no flag, never clears counter
// - force bits are strobes reading zero
// - 16-bit access through shared high temp byte
// - counter write blocks next timer clock match
// - capture source pin or analog comparator
// - low byte at base, high at base+1
// - capture-top modes set flag at top
// - flag clears on vector or written one
// - capture top 8,10,12,14; compare top 4,9,11,15
package tcc_pkg;

    // ------------------------------------------------
    // register offsets
    // ------------------------------------------------
    localparam logic [7:0] OFS_CTRL_A = 8'h80;
    localparam logic [7:0] OFS_CTRL_B = 8'h81;
    localparam logic [7:0] OFS_CTRL_C = 8'h82;
    localparam logic [7:0] OFS_CNT = 8'h84;
    localparam logic [7:0] OFS_CAP = 8'h86;
    localparam logic [7:0] OFS_CMPA = 8'h88;
    localparam logic [7:0] OFS_STAT = 8'h8c;
    localparam logic [7:0] OFS_IEN = 8'h8d;
    localparam logic [7:0] OFS_HIGH = 8'h01;

    // ------------------------------------------------
    // field positions
    // ------------------------------------------------
    localparam int B_NOISE = 7;
    localparam int B_EDGE = 6;
    localparam int B_WM3 = 4;
    localparam int B_WM2 = 3;
    localparam int B_FORCE_A = 7;
    localparam int B_FORCE_B = 6;
    localparam int B_ACT_A = 6;
    localparam int B_ACT_B = 4;
    localparam int B_FLAG = 0;
    localparam int B_CAP_IEN = 0;
    localparam int B_CAP_SRC = 1;
    localparam logic [7:0] CTRL_B_MASK = 8'hdf;

    // ------------------------------------------------
    // reset values and counts
    // ------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] MAX_WORD = 16'hffff;
    localparam int FILT_SAMPLES = 4;
    localparam int PRE_W = 10;

    // ------------------------------------------------
    // clock select and compare action codes
    // ------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcc_bus_t;

    typedef struct packed {
        logic capture_pin;
        logic comparator_out;
        logic ext_count_clock_pin;
    } tcc_pins_t;

endpackage

//--- tb/tcc_pin_model.sv
// Purpose: far side pins: capture source and external count clock
// Assumes: bench sets levels and requests clock runs
// Notes: count clock stands still between runs
`timescale 1ns/1ps
module tcc_pin_model (
    // clock
    input wire logic clock,
    // requests
    input wire logic cap_level,
    input wire logic cmp_level,
    input wire logic [3:0] ext_toggles,
    input wire logic ext_go,
    input wire logic [3:0] half_period,
    // pins
    output tcc_pkg::tcc_pins_t pins,
    output logic ext_busy
);
    logic [3:0] left_q, ph_q;
    logic ext_q;
    assign pins = {cap_level, cmp_level, ext_q};
    assign ext_busy = (left_q != 4'h0);
    initial begin
        left_q = 4'h0;
        ph_q = 4'h0;
        ext_q = 1'b0;
    end
    // slow half periods stress the pin sampler
    always @(posedge clock) begin
        if (ext_go) begin
            left_q <= ext_toggles;
            ph_q <= half_period;
        end else if (left_q != 4'h0) begin
            ph_q <= (ph_q == 4'h0) ? half_period : ph_q - 4'h1;
            if (ph_q == 4'h0) begin
                ext_q <= !ext_q;
                left_q <= left_q - 4'h1;
            end
        end
    end
endmodule

//--- tb/tcc_timer_properties.sv
// Purpose: port-level checks of the timer control slice
// Assumes: one clock, synchronous reset, registers at package offsets
// Notes: shadows of written control bits stand in for hidden state
`timescale 1ns/1ps
module tcc_timer_properties import tcc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // register port
    input wire tcc_pkg::tcc_bus_t bus,
    input wire logic [7:0] rdata,
    // pins and outputs
    input wire tcc_pkg::tcc_pins_t pins,
    input wire logic capture_vector_taken,
    input wire logic capture_irq,
    input wire logic wave_out_a,
    input wire logic wave_out_b
);
    // ----
    // shadows and decode
    // ----
    logic [7:0] ca_q, cb_q, ie_q;
    wire [3:0] wm = {cb_q[B_WM3], cb_q[B_WM2], ca_q[1:0]};
    wire npwm = (wm == 4'h0) || (wm == 4'h4) || (wm == 4'hc);
    wire ctop = (wm == 4'h8) || (wm == 4'ha) || (wm == 4'hc) || (wm == 4'he);
    wire stop = (cb_q[2:0] == CS_STOP);
    wire wr_c = bus.wr && (bus.addr == OFS_CTRL_C);
    wire pin_on = ie_q[B_CAP_IEN] && !ie_q[B_CAP_SRC] && !ctop && !bus.wr;
    wire top_k = ctop && stop && ie_q[B_CAP_IEN];
    wire pwm_k = !npwm && stop;
    always_ff @(posedge clock) begin
        if (srst) begin
            ca_q <= 8'h00;
            cb_q <= 8'h00;
            ie_q <= 8'h00;
        end else if (bus.wr) begin
            if (bus.addr == OFS_CTRL_A) ca_q <= bus.wdata;
            if (bus.addr == OFS_CTRL_B) cb_q <= bus.wdata;
            if (bus.addr == OFS_IEN) ie_q <= bus.wdata;
        end
    end
    // ----
    // assertions
    // ----
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);
    a_force_reads_zero: assert property (
        bus.rd && bus.addr == OFS_CTRL_C |=> rdata == 8'h00)
        else $error("force register read not zero");
    a_reset_quiet: assert property (
        $past(srst) |-> !capture_irq && !wave_out_a && !wave_out_b)
        else $error("outputs not quiet after reset");
    a_irq_needs_en: assert property (
        capture_irq |-> $past(ie_q[B_CAP_IEN]))
        else $error("capture irq without enable");
    a_cap_edge_fast: assert property (
        pin_on && !cb_q[B_NOISE] && (cb_q[B_EDGE] ? $rose(pins.capture_pin)
        : $fell(pins.capture_pin)) ##1 !bus.wr [*2] |-> ##1 capture_irq)
        else $error("capture edge not flagged in time");
    a_cap_edge_filt: assert property (
        pin_on && cb_q[B_NOISE] && (cb_q[B_EDGE] ? $rose(pins.capture_pin)
        : $fell(pins.capture_pin)) ##1
        ($stable(pins.capture_pin) && !bus.wr) [*6] |-> ##1 capture_irq)
        else $error("filtered capture not flagged in time");
    a_cap_top_off: assert property (
        $past(top_k, 3) && $past(top_k, 2) && $past(top_k) && top_k
        |-> !$rose(capture_irq))
        else $error("capture active while capture is top");
    a_force_set: assert property (
        wr_c && bus.wdata[B_FORCE_A] && npwm && ca_q[7:6] == ACT_SET
        |=> ##[0:1] wave_out_a)
        else $error("forced set did not reach output");
    a_pwm_no_force: assert property (
        $past(pwm_k) && pwm_k |-> $stable(wave_out_a) && $stable(wave_out_b))
        else $error("output moved in pwm mode while stopped");
endmodule

bind tcc_timer tcc_timer_properties u_props (
    .clock(clock), .srst(srst), .bus(bus), .rdata(rdata), .pins(pins),
    .capture_vector_taken(capture_vector_taken),
    .capture_irq(capture_irq), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b));

//--- tb/tcc_timer_tb_top.sv
// Purpose: self-checking bench of the timer control slice
// Assumes: reads answered one cycle after the strobe
// Notes: counts with prescaler allow a small phase window
`timescale 1ns/1ps
module tcc_timer_tb_top;
    import tcc_pkg::*;
    logic clock, srst, vt, irq, wa, wb, cap_l, cmp_l, ext_go, busy;
    logic rd_d = 1'b0;
    logic [3:0] ext_n, half;
    logic [7:0] rdata;
    logic [31:0] v;
    tcc_bus_t bus;
    tcc_pins_t pins;
    int n_errors = 0, checks_done = 0, seed = 32'he510;
    logic [7:0] lo_q[$], hi_q[$];
    string nm_q[$];
    logic [7:0] offs [9] = '{8'h81, 8'h82, 8'h84, 8'h85, 8'h86, 8'h87,
        8'h88, 8'h89, 8'h8f};
    int divs [5] = '{1, 8, 64, 256, 1024};
    tcc_timer uut (.clock(clock), .srst(srst), .bus(bus), .rdata(rdata),
        .pins(pins), .capture_vector_taken(vt), .capture_irq(irq),
        .wave_out_a(wa), .wave_out_b(wb));
    tcc_pin_model far (.clock(clock), .cap_level(cap_l), .cmp_level(cmp_l),
        .ext_toggles(ext_n), .ext_go(ext_go), .half_period(half),
        .pins(pins), .ext_busy(busy));
    always #5 clock = ~clock;
    // ----
    // bus tasks and checks
    // ----
    task automatic chk(input string n, input logic [7:0] s,
        input logic [7:0] lo, input logic [7:0] hi);
        checks_done++;
        if ((s >= lo && s <= hi) !== 1'b1) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", n, lo, s);
        end
    endtask
    task automatic cyc(input int n);
        bus <= '0;
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input string n, input logic [7:0] t = 8'h00);
        lo_q.push_back(e);
        hi_q.push_back(e + t);
        nm_q.push_back(n);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
    endtask
    task automatic w16(input logic [7:0] a, input logic [15:0] d);
        wr(a + OFS_HIGH, d[15:8]);
        wr(a, d[7:0]);
    endtask
    task automatic r16(input logic [7:0] a, input logic [15:0] d);
        rd(a, d[7:0], "low");
        rd(a + OFS_HIGH, d[15:8], "high");
    endtask
    task automatic ext_run(input logic [3:0] n);
        ext_n <= n;
        ext_go <= 1'b1;
        half <= {1'b0, 3'($random(seed))};
        cyc(1);
        ext_go <= 1'b0;
        cyc(1);
        for (int i = 0; i < 200 && busy; i++) cyc(1);
        cyc(4);
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // read results checked in issue order
    always @(posedge clock) begin
        if (rd_d) chk(nm_q.pop_front(), rdata, lo_q[0], hi_q[0]);
        if (rd_d) void'(lo_q.pop_front());
        if (rd_d) void'(hi_q.pop_front());
        rd_d <= bus.rd;
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        give_verdict();
    end
    // ----
    // main sequence
    // ----
    initial begin
        clock = 1'b0;
        srst = 1'b1;
        bus = '0;
        {vt, cap_l, cmp_l, ext_go} = 4'h0;
        ext_n = 4'h0;
        half = 4'h1;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        cyc(1);
        foreach (offs[i]) rd(offs[i], 8'h00, "reset");
        v = $random(seed);
        wr(8'h8f, 8'hff);
        rd(8'h8f, 8'h00, "unmapped");
        w16(OFS_CMPA, v[15:0]);
        r16(OFS_CMPA, v[15:0]);
        wr(OFS_CNT + OFS_HIGH, v[23:16]);
        wr(OFS_CAP, v[7:0]);
        r16(OFS_CAP, {v[23:16], v[7:0]});
        for (int c = 1; c < 6; c++) begin
            w16(OFS_CNT, RST_WORD);
            wr(OFS_CTRL_B, 8'(c));
            cyc(32 * divs[c - 1]);
            wr(OFS_CTRL_B, 8'h00);
            rd(OFS_CNT, 8'd31, "prescaled count", 8'd3);
            rd(OFS_CNT + OFS_HIGH, 8'h00, "count high");
        end
        for (int c = 7; c > 5; c--) begin
            w16(OFS_CNT, RST_WORD);
            wr(OFS_CTRL_B, 8'(c));
            ext_run(4'd3);
            wr(OFS_CTRL_B, 8'h00);
            rd(OFS_CNT, 8'h02, "external count");
        end
        wr(OFS_IEN, 8'h01);
        w16(OFS_CNT, v[15:0]);
        cap_l <= 1'b1;
        cyc(4);
        rd(OFS_STAT, 8'h00, "rise ignored");
        cap_l <= 1'b0;
        cyc(4);
        chk("irq", {7'h0, irq}, 8'h01, 8'h01);
        r16(OFS_CAP, v[15:0]);
        wr(OFS_STAT, 8'h01);
        rd(OFS_STAT, 8'h00, "flag cleared");
        wr(OFS_CTRL_B, 8'h40);
        w16(OFS_CNT, v[31:16]);
        cap_l <= 1'b1;
        cyc(4);
        r16(OFS_CAP, v[31:16]);
        vt <= 1'b1;
        cyc(1);
        vt <= 1'b0;
        rd(OFS_STAT, 8'h00, "vector clear");
        wr(OFS_CTRL_B, 8'hc0);
        cap_l <= 1'b0;
        cyc(8);
        cap_l <= 1'b1;
        cyc(3);
        cap_l <= 1'b0;
        cyc(8);
        rd(OFS_STAT, 8'h00, "glitch");
        cap_l <= 1'b1;
        cyc(10);
        rd(OFS_STAT, 8'h01, "filtered");
        wr(OFS_STAT, 8'h01);
        wr(OFS_IEN, 8'h03);
        cap_l <= 1'b0;
        cyc(8);
        cap_l <= 1'b1;
        cyc(8);
        rd(OFS_STAT, 8'h00, "pin off");
        cmp_l <= 1'b1;
        cyc(8);
        rd(OFS_STAT, 8'h01, "comparator");
        wr(OFS_STAT, 8'h01);
        wr(OFS_IEN, 8'h01);
        wr(OFS_CTRL_B, 8'h58);
        cap_l <= 1'b0;
        cyc(4);
        cap_l <= 1'b1;
        cyc(4);
        rd(OFS_STAT, 8'h00, "top mode");
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_A, 8'hd0);
        wr(OFS_CTRL_C, 8'hc0);
        cyc(3);
        chk("wave a", {7'h0, wa}, 8'h01, 8'h01);
        chk("wave b", {7'h0, wb}, 8'h01, 8'h01);
        rd(OFS_CTRL_C, 8'h00, "force read");
        rd(OFS_STAT, 8'h00, "force flag");
        wr(OFS_CTRL_A, 8'ha2);
        wr(OFS_CTRL_B, 8'h18);
        wr(OFS_CTRL_C, 8'hc0);
        cyc(3);
        chk("pwm a", {7'h0, wa}, 8'h01, 8'h01);
        wr(OFS_CTRL_A, 8'ha0);
        wr(OFS_CTRL_B, 8'h08);
        wr(OFS_CTRL_C, 8'hc0);
        cyc(3);
        chk("ctc a", {7'h0, wa}, 8'h00, 8'h00);
        chk("ctc b", {7'h0, wb}, 8'h00, 8'h00);
        // counter only ever rewritten while stopped
        wr(OFS_CTRL_A, 8'h40);
        w16(OFS_CMPA, 16'h0005);
        w16(OFS_CNT, 16'h0005);
        wr(OFS_CTRL_B, 8'h09);
        wr(OFS_CTRL_B, 8'h08);
        rd(OFS_CNT, 8'h00, "ctc wrap");
        chk("blocked a", {7'h0, wa}, 8'h00, 8'h00);
        wr(OFS_CTRL_B, 8'h09);
        cyc(5);
        wr(OFS_CTRL_B, 8'h08);
        rd(OFS_CNT, 8'h00, "ctc period");
        chk("match a", {7'h0, wa}, 8'h01, 8'h01);
        w16(OFS_CNT, 16'h0003);
        wr(OFS_CTRL_C, 8'h80);
        rd(OFS_CNT, 8'h03, "force keeps count");
        chk("force toggle", {7'h0, wa}, 8'h00, 8'h00);
        w16(OFS_CAP, 16'h0003);
        w16(OFS_CNT, RST_WORD);
        wr(OFS_CTRL_B, 8'h19);
        cyc(6);
        wr(OFS_CTRL_B, 8'h18);
        rd(OFS_STAT, 8'h01, "top flag");
        rd(OFS_CNT, 8'h03, "capture top");
        cyc(2);
        give_verdict();
    end
endmodule
